// ---- design/integer_alu_map.svh ----
// Purpose: offsets, field positions and constant values of the integer datapath
// Assumes: 32-bit words, 7-bit operation code supplied by decode
// Notes: definitions only
`ifndef INTEGER_ALU_MAP_SVH
`define INTEGER_ALU_MAP_SVH

`define WORD_W 32
`define OPC_W 7
`define SHIFT_W 5
`define VEC_W 8
`define REL_W 4
`define ST_W 4
// arithmetic opcode fields
`define AR_KIND_HI 4
`define AR_KIND_LO 3
`define AR_CARRY_BIT 2
`define AR_TRAP_HI 1
`define AR_TRAP_LO 0
`define KIND_ADD 2'h0
`define KIND_SUB 2'h1
`define KIND_REV 2'h2
`define TRAP_NONE 2'h0
`define TRAP_SIGNED 2'h1
`define TRAP_UNSIGNED 2'h2
// relation field of compare and assert opcodes
`define REL_HI 3
`define REL_LO 0
// boolean encoding
`define BOOL_TRUE 32'h80000000
`define BOOL_FALSE 32'h00000000
`define BOOL_BIT 31
// status register bits
`define ST_C 0
`define ST_V 1
`define ST_N 2
`define ST_Z 3
`define ST_RESET 4'h0
// user-mode assert vectors below this limit are refused
`define USER_VEC_LIMIT 8'h40

`endif

// ---- design/integer_alu_pkg.sv ----
// Purpose: types of the integer datapath
// Assumes: opcode encoding is private to decode and this block
// Notes: arithmetic codes carry kind, carry-use and trap mode as fields
package integer_alu_pkg;

   typedef enum logic [6:0] {
      op_add = 7'h00, op_sum_trap_signed = 7'h01, op_sum_trap_unsigned = 7'h02,
      op_sum_with_flag = 7'h04, op_sum_with_flag_ts = 7'h05, op_sum_with_flag_tu = 7'h06,
      op_diff = 7'h08, op_diff_trap_signed = 7'h09, op_diff_trap_unsigned = 7'h0A,
      op_diff_with_flag = 7'h0C, op_diff_with_flag_ts = 7'h0D, op_diff_with_flag_tu = 7'h0E,
      op_reverse_diff = 7'h10, op_reverse_diff_ts = 7'h11, op_reverse_diff_tu = 7'h12,
      op_reverse_diff_flag = 7'h14, op_reverse_diff_flag_ts = 7'h15,
      op_reverse_diff_flag_tu = 7'h16,
      op_and = 7'h18, op_and_not = 7'h19, op_nand = 7'h1A, op_or = 7'h1B,
      op_nor = 7'h1C, op_xor = 7'h1D, op_xnor = 7'h1E,
      op_cmp_eq = 7'h20, op_cmp_neq = 7'h21, op_cmp_lt = 7'h22, op_cmp_ltu = 7'h23,
      op_cmp_le = 7'h24, op_cmp_leu = 7'h25, op_cmp_gt = 7'h26, op_cmp_gtu = 7'h27,
      op_cmp_ge = 7'h28, op_cmp_geu = 7'h29, op_any_byte_equal_test = 7'h2A,
      op_assert_equal = 7'h30, op_assert_neq = 7'h31, op_assert_lt = 7'h32,
      op_assert_ltu = 7'h33, op_assert_le = 7'h34, op_assert_leu = 7'h35,
      op_assert_gt = 7'h36, op_assert_gtu = 7'h37, op_assert_ge = 7'h38,
      op_assert_geu = 7'h39,
      op_shift_left_zero = 7'h3A, op_shift_right_zero = 7'h3B,
      op_shift_right_sign = 7'h3C, op_funnel_extract = 7'h3D,
      op_full_product = 7'h40, op_product_bit_step = 7'h41,
      op_product_bit_step_unsigned = 7'h42, op_product_final_step = 7'h43,
      op_full_quotient = 7'h44, op_quotient_setup_step = 7'h45,
      op_quotient_bit_step = 7'h46, op_quotient_final_step = 7'h47,
      op_remainder_fixup = 7'h48
   } op_e;

   typedef enum logic [3:0] {
      rel_eq = 4'h0, rel_neq = 4'h1, rel_lt = 4'h2, rel_ltu = 4'h3, rel_le = 4'h4,
      rel_leu = 4'h5, rel_gt = 4'h6, rel_gtu = 4'h7, rel_ge = 4'h8, rel_geu = 4'h9
   } rel_e;

endpackage : integer_alu_pkg

// ---- design/integer_alu_compare_shift.sv ----
// Purpose: 32-bit integer execution datapath: arithmetic, steps, compare, logic, shift
// Assumes: one operation per cycle from decode; results appear one edge later
// Notes: helper register and status register live here
//
// Summary of operation
// - add operands; signed or unsigned overflow variants raise range trap
// - carry add sums operands plus stored carry, plain or trapping
// - subtract first minus second; signed overflow or unsigned underflow traps
// - carry subtract is first minus second minus one plus carry
// - reverse subtract is second minus first, with carry and trap variants
// - multiply step sequence gives 64-bit product, high word result, low in helper
// - signed and unsigned multiply bit steps, plus a final step
// - divide setup, bit, final and remainder steps; full divide defined
// - compares write true or false for six relations, signed and unsigned
// - byte test is true when any byte lane of operands matches
// - asserts test compare relations; failure traps with instruction vector
// - user-mode assert failure with vector 0 to 63 becomes protection trap
// - logical ops: and, and-not, nand, or, nor, xor, xnor
// - logical ops also update the status register
// - shift amount is a 5-bit count, 0 to 31
// - left and logical right fill zeros; arithmetic right fills sign
// - funnel: first and second concatenated, shifted left, upper word returned
// - full multiply and divide are not computed; each raises its trap
// - all arithmetic updates status including carry for chaining
`timescale 1ns/1ns
`include "integer_alu_map.svh"

module integer_alu_compare_shift (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // issued operation
   input wire logic op_valid,
   input wire logic [`OPC_W-1:0] opcode,
   input wire logic [`WORD_W-1:0] first_operand,
   input wire logic [`WORD_W-1:0] second_operand,
   input wire logic [`SHIFT_W-1:0] funnel_shift_count,
   input wire logic [`VEC_W-1:0] trap_vector_number,
   input wire logic user_mode,
   // helper register load
   input wire logic q_load,
   input wire logic [`WORD_W-1:0] q_load_data,
   // results
   output logic [`WORD_W-1:0] result_register,
   output logic result_write,
   output logic op_done,
   output logic [`WORD_W-1:0] helper_q,
   output logic [`ST_W-1:0] alu_status,
   // traps
   output logic range_trap,
   output logic assert_trap,
   output logic protect_trap,
   output logic product_trap,
   output logic quotient_trap,
   output logic [`VEC_W-1:0] trap_vector
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire logic [1:0] ar_kind = opcode[`AR_KIND_HI:`AR_KIND_LO];
   wire logic ar_carry = opcode[`AR_CARRY_BIT];
   wire logic [1:0] ar_trap = opcode[`AR_TRAP_HI:`AR_TRAP_LO];
   wire logic [`REL_W-1:0] rel = opcode[`REL_HI:`REL_LO];
   wire logic is_arith = (opcode <= integer_alu_pkg::op_reverse_diff_flag_tu) &&
                         (ar_trap != 2'h3);
   wire logic is_cmp = (opcode >= integer_alu_pkg::op_cmp_eq) &&
                       (opcode <= integer_alu_pkg::op_cmp_geu);
   wire logic is_asrt = (opcode >= integer_alu_pkg::op_assert_equal) &&
                        (opcode <= integer_alu_pkg::op_assert_geu);
   wire logic carry_flag = alu_status[`ST_C];

   // ----------------------------------------------------------------
   // adder, shared by every add and subtract form
   // ----------------------------------------------------------------
   // subtraction is x + ~y + 1; carry forms replace the 1 by the stored carry
   wire logic [`WORD_W-1:0] ad_x = (ar_kind == `KIND_REV) ? second_operand : first_operand;
   wire logic [`WORD_W-1:0] ad_y = (ar_kind == `KIND_ADD) ? second_operand :
                                   ((ar_kind == `KIND_REV) ? ~first_operand : ~second_operand);
   wire logic ad_cin = ar_carry ? carry_flag : (ar_kind != `KIND_ADD);
   wire logic [`WORD_W:0] ad_sum = {1'b0, ad_x} + {1'b0, ad_y} + {32'h0, ad_cin};
   wire logic ad_sovf = (ad_x[31] == ad_y[31]) && (ad_sum[31] != ad_x[31]);
   // add overflows on carry out; subtract underflows on missing carry (borrow)
   wire logic ad_urange = (ar_kind == `KIND_ADD) ? ad_sum[`WORD_W] : ~ad_sum[`WORD_W];
   wire logic range_hit = ((ar_trap == `TRAP_SIGNED) && ad_sovf) ||
                          ((ar_trap == `TRAP_UNSIGNED) && ad_urange);

   // ----------------------------------------------------------------
   // multiply and divide steps
   // ----------------------------------------------------------------
   // signed sequence: 31 signed steps then a final step that weighs the
   // multiplier sign bit negatively; unsigned sequence: 32 unsigned steps
   wire logic mp_final = (opcode == integer_alu_pkg::op_product_final_step);
   wire logic mp_signed = (opcode != integer_alu_pkg::op_product_bit_step_unsigned);
   wire logic [`WORD_W-1:0] mp_addend = !helper_q[0] ? `BOOL_FALSE :
                                        (mp_final ? (~second_operand + 32'h1) : second_operand);
   wire logic [`WORD_W:0] mp_sum = {mp_signed & first_operand[31], first_operand} +
                                   {mp_signed & mp_addend[31], mp_addend};
   // restoring divide: no correction needed after the final step
   wire logic [`WORD_W:0] dv_trial = {first_operand, helper_q[31]};
   wire logic [`WORD_W:0] dv_diff = dv_trial - {1'b0, second_operand};
   wire logic dv_fit = (dv_trial >= {1'b0, second_operand});
   wire logic [`WORD_W-1:0] dv_rem = dv_fit ? dv_diff[`WORD_W-1:0] : dv_trial[`WORD_W-1:0];
   wire logic [`WORD_W-1:0] dv_quot = {helper_q[30:0], dv_fit};

   // ----------------------------------------------------------------
   // compare
   // ----------------------------------------------------------------
   wire logic c_eq = (first_operand == second_operand);
   wire logic c_lt = ($signed(first_operand) < $signed(second_operand));
   wire logic c_ltu = (first_operand < second_operand);
   logic [3:0] byte_eq;
   logic rel_hold;

   for (genvar i = 0; i < 4; i++) begin : g_byte
      assign byte_eq[i] = (first_operand[8*i +: 8] == second_operand[8*i +: 8]);
   end

   always_comb begin
      case (rel)
         integer_alu_pkg::rel_eq: rel_hold = c_eq;
         integer_alu_pkg::rel_neq: rel_hold = !c_eq;
         integer_alu_pkg::rel_lt: rel_hold = c_lt;
         integer_alu_pkg::rel_ltu: rel_hold = c_ltu;
         integer_alu_pkg::rel_le: rel_hold = c_lt || c_eq;
         integer_alu_pkg::rel_leu: rel_hold = c_ltu || c_eq;
         integer_alu_pkg::rel_gt: rel_hold = !(c_lt || c_eq);
         integer_alu_pkg::rel_gtu: rel_hold = !(c_ltu || c_eq);
         integer_alu_pkg::rel_ge: rel_hold = !c_lt;
         integer_alu_pkg::rel_geu: rel_hold = !c_ltu;
         default: rel_hold = 1'b0;
      endcase
   end

   wire logic [`WORD_W-1:0] cmp_bool = rel_hold ? `BOOL_TRUE : `BOOL_FALSE;
   wire logic [`WORD_W-1:0] byte_bool = (|byte_eq) ? `BOOL_TRUE : `BOOL_FALSE;
   // only the top bit is consulted, so any true encoding would pass
   wire logic asrt_fail = is_asrt && !cmp_bool[`BOOL_BIT];
   wire logic asrt_prot = asrt_fail && user_mode &&
                          (trap_vector_number < `USER_VEC_LIMIT);

   // ----------------------------------------------------------------
   // shifts
   // ----------------------------------------------------------------
   wire logic [`SHIFT_W-1:0] sh_amt = second_operand[`SHIFT_W-1:0];
   wire logic [`WORD_W-1:0] sh_left = first_operand << sh_amt;
   wire logic [`WORD_W-1:0] sh_right = first_operand >> sh_amt;
   wire logic [`WORD_W-1:0] sh_sign = `WORD_W'($signed(first_operand) >>> sh_amt);
   wire logic [2*`WORD_W-1:0] fn_wide = {first_operand, second_operand} << funnel_shift_count;

   // ----------------------------------------------------------------
   // result selection
   // ----------------------------------------------------------------
   logic [`WORD_W-1:0] res_next;
   logic [`WORD_W-1:0] q_next;
   logic [`ST_W-1:0] st_next;
   logic wr_next;
   logic nz_upd;

   always_comb begin
      res_next = `BOOL_FALSE;
      q_next = q_load ? q_load_data : helper_q;
      st_next = alu_status;
      wr_next = 1'b0;
      nz_upd = 1'b0;
      if (op_valid && is_arith) begin
         res_next = ad_sum[`WORD_W-1:0];
         wr_next = 1'b1;
         nz_upd = 1'b1;
         st_next[`ST_C] = ad_sum[`WORD_W];
         st_next[`ST_V] = ad_sovf;
      end else if (op_valid && (is_cmp || is_asrt)) begin
         res_next = cmp_bool;
         wr_next = is_cmp;
      end else if (op_valid) begin
         wr_next = 1'b1;
         case (opcode)
            integer_alu_pkg::op_and: res_next = first_operand & second_operand;
            integer_alu_pkg::op_and_not: res_next = first_operand & ~second_operand;
            integer_alu_pkg::op_nand: res_next = ~(first_operand & second_operand);
            integer_alu_pkg::op_or: res_next = first_operand | second_operand;
            integer_alu_pkg::op_nor: res_next = ~(first_operand | second_operand);
            integer_alu_pkg::op_xor: res_next = first_operand ^ second_operand;
            integer_alu_pkg::op_xnor: res_next = ~(first_operand ^ second_operand);
            integer_alu_pkg::op_any_byte_equal_test: res_next = byte_bool;
            integer_alu_pkg::op_shift_left_zero: res_next = sh_left;
            integer_alu_pkg::op_shift_right_zero: res_next = sh_right;
            integer_alu_pkg::op_shift_right_sign: res_next = sh_sign;
            integer_alu_pkg::op_funnel_extract: begin
               res_next = fn_wide[2*`WORD_W-1:`WORD_W];
            end
            integer_alu_pkg::op_product_bit_step,
            integer_alu_pkg::op_product_bit_step_unsigned,
            integer_alu_pkg::op_product_final_step: begin
               res_next = mp_sum[`WORD_W:1];
               q_next = {mp_sum[0], helper_q[`WORD_W-1:1]};
            end
            integer_alu_pkg::op_quotient_setup_step: begin
               res_next = first_operand;
               q_next = second_operand;
            end
            integer_alu_pkg::op_quotient_bit_step: begin
               res_next = dv_rem;
               q_next = dv_quot;
            end
            integer_alu_pkg::op_quotient_final_step: begin
               res_next = dv_quot;
               q_next = dv_rem;
            end
            integer_alu_pkg::op_remainder_fixup: res_next = helper_q;
            default: wr_next = 1'b0; // full ops and undefined codes write nothing
         endcase
         nz_upd = wr_next && (opcode != integer_alu_pkg::op_any_byte_equal_test) &&
                  (opcode < integer_alu_pkg::op_shift_left_zero ||
                   opcode > integer_alu_pkg::op_funnel_extract);
         if (nz_upd && (opcode <= integer_alu_pkg::op_xnor)) begin
            st_next[`ST_V] = 1'b0;
         end else if (nz_upd) begin
            st_next[`ST_C] = 1'b0;
            st_next[`ST_V] = 1'b0;
         end
      end
      if (nz_upd) begin
         st_next[`ST_N] = res_next[`WORD_W-1];
         st_next[`ST_Z] = (res_next == `BOOL_FALSE);
      end
   end

   // ----------------------------------------------------------------
   // state and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_register <= `BOOL_FALSE;
         helper_q <= `BOOL_FALSE;
         alu_status <= `ST_RESET;
      end else begin
         if (wr_next) begin
            result_register <= res_next;
         end
         helper_q <= q_next;
         alu_status <= st_next;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_write <= 1'b0;
         op_done <= 1'b0;
         range_trap <= 1'b0;
         assert_trap <= 1'b0;
         protect_trap <= 1'b0;
         product_trap <= 1'b0;
         quotient_trap <= 1'b0;
         trap_vector <= 8'h00;
      end else begin
         result_write <= wr_next;
         op_done <= op_valid;
         range_trap <= op_valid && is_arith && range_hit;
         assert_trap <= op_valid && asrt_fail && !asrt_prot;
         protect_trap <= op_valid && asrt_prot;
         product_trap <= op_valid && (opcode == integer_alu_pkg::op_full_product);
         quotient_trap <= op_valid && (opcode == integer_alu_pkg::op_full_quotient);
         trap_vector <= (op_valid && asrt_fail) ? trap_vector_number : trap_vector;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sum_value_a: assert property (op_valid && opcode == integer_alu_pkg::op_add |=>
      result_write && result_register == $past(first_operand) + $past(second_operand))
      else $error("add result wrong");
   sum_range_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_sum_trap_unsigned &&
      first_operand > ~second_operand |=> range_trap && !assert_trap)
      else $error("unsigned add overflow not trapped");
   carry_sum_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_sum_with_flag |=>
      result_register == $past(first_operand) + $past(second_operand) + $past(carry_flag))
      else $error("carry add result wrong");
   diff_trap_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_diff_trap_unsigned
      |=> range_trap == ($past(first_operand) < $past(second_operand)))
      else $error("unsigned subtract underflow trap wrong");
   diff_flag_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_diff_with_flag |=>
      result_register == $past(first_operand) - $past(second_operand) - 32'h1
      + $past(carry_flag))
      else $error("carry subtract result wrong");
   rev_diff_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_reverse_diff |=>
      result_register == $past(second_operand) - $past(first_operand))
      else $error("reverse subtract result wrong");
   mul_step_a: assert property (op_valid && !helper_q[0] &&
      opcode == integer_alu_pkg::op_product_bit_step_unsigned |=>
      result_register == ($past(first_operand) >> 1) && helper_q[31] == $past(first_operand[0]))
      else $error("multiply step wrong");
   div_step_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_quotient_bit_step &&
      {first_operand, helper_q[31]} < {1'b0, second_operand} |=>
      result_register == {$past(first_operand[30:0]), $past(helper_q[31])} && !helper_q[0])
      else $error("divide step wrong");
   full_trap_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_full_product |=>
      product_trap && !result_write && !quotient_trap)
      else $error("full multiply not trapped");
   bool_lt_a: assert property (op_valid && opcode == integer_alu_pkg::op_cmp_lt |=>
      result_register == (($signed($past(first_operand)) < $signed($past(second_operand))) ?
      `BOOL_TRUE : `BOOL_FALSE))
      else $error("signed compare result wrong");
   byte_eq_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_any_byte_equal_test
      && first_operand[15:8] == second_operand[15:8] |=> result_register == `BOOL_TRUE)
      else $error("byte compare missed a match");
   assert_pass_a: assert property (op_valid && opcode == integer_alu_pkg::op_assert_ltu
      && c_ltu |=> !assert_trap && !protect_trap && !result_write)
      else $error("passing assert trapped");
   protect_a: assert property (op_valid && opcode == integer_alu_pkg::op_assert_equal
      && !c_eq && user_mode && trap_vector_number < 8'h40 |=> protect_trap && !assert_trap)
      else $error("user assert not turned into protection trap");
   logic_status_a: assert property (op_valid && opcode == integer_alu_pkg::op_xor |=>
      alu_status[`ST_Z] == ($past(first_operand) == $past(second_operand)))
      else $error("logical op left status stale");
   shift_left_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_shift_left_zero
      |=> result_register == $past(first_operand) << $past(second_operand[4:0]))
      else $error("left shift wrong");
   funnel_rot_a: assert property (op_valid &&
      opcode == integer_alu_pkg::op_funnel_extract
      && c_eq && funnel_shift_count == 5'h08 |=>
      result_register == {$past(first_operand[23:0]), $past(first_operand[31:24])})
      else $error("funnel rotate wrong");
   carry_chain_a: assert property (op_valid && opcode == integer_alu_pkg::op_add |=>
      alu_status[`ST_C] == ($past(first_operand) > ~$past(second_operand)))
      else $error("add carry not recorded");

   range_seen_c: cover property (op_valid && opcode == integer_alu_pkg::op_sum_trap_signed
      ##1 range_trap);
   protect_seen_c: cover property (op_valid && is_asrt ##1 protect_trap);
   chain_seen_c: cover property (op_valid && opcode == integer_alu_pkg::op_add ##1
      op_valid && opcode == integer_alu_pkg::op_sum_with_flag && carry_flag);
   quot_seen_c: cover property (op_valid && opcode == integer_alu_pkg::op_quotient_final_step
      ##1 result_write);

endmodule : integer_alu_compare_shift

// ---- verification/integer_alu_compare_shift_test.sv ----
// Purpose: self-checking bench of the integer datapath
// Assumes: shift ops take their count from second_operand bits 4:0
// Notes: driver queues expected results, a monitor pops one per op_done
`timescale 1ns/1ns
`include "integer_alu_map.svh"

module integer_alu_compare_shift_test;
   typedef struct {logic [31:0] res; logic [5:0] tr; logic [3:0] st; logic [31:0] q;
      logic [7:0] vec;} note_s;
   logic sys_clk = 0, arst_n = 0, op_valid = 0, user_mode = 0, q_load = 0;
   logic [6:0] opcode = 0;
   logic [31:0] first_operand = 0, second_operand = 0, q_load_data = 0, seed = 32'hCAEE;
   logic [4:0] funnel_shift_count = 0;
   logic [7:0] trap_vector_number = 0, tv_m = 0;
   logic [31:0] d_m = 0, q_m = 0;
   logic [3:0] st_m = 0;
   wire logic [31:0] result_register, helper_q;
   wire logic result_write, op_done, range_trap, assert_trap, protect_trap;
   wire logic product_trap, quotient_trap;
   wire logic [3:0] alu_status;
   wire logic [7:0] trap_vector;
   note_s notes[$];
   int error_cnt = 0, check_count = 0;

   integer_alu_compare_shift u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid),
      .opcode(opcode), .first_operand(first_operand), .second_operand(second_operand),
      .funnel_shift_count(funnel_shift_count), .trap_vector_number(trap_vector_number),
      .user_mode(user_mode), .q_load(q_load), .q_load_data(q_load_data),
      .result_register(result_register), .result_write(result_write), .op_done(op_done),
      .helper_q(helper_q), .alu_status(alu_status), .range_trap(range_trap),
      .assert_trap(assert_trap), .protect_trap(protect_trap), .product_trap(product_trap),
      .quotient_trap(quotient_trap), .trap_vector(trap_vector));

   always #10 sys_clk = ~sys_clk;

   // ----------------------------------------
   // reference and checking
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic rel_ok(input logic [3:0] r, input logic [31:0] a, b);
      case (r)
         0: return a == b;
         1: return a != b;
         2: return $signed(a) < $signed(b);
         3: return a < b;
         4: return $signed(a) <= $signed(b);
         5: return a <= b;
         6: return $signed(a) > $signed(b);
         7: return a > b;
         8: return $signed(a) >= $signed(b);
         default: return a >= b;
      endcase
   endfunction : rel_ok

   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (e !== g) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   // issue one op at this edge and queue what it must produce
   task automatic issue(input logic [6:0] op, input logic [31:0] a, b, input logic [4:0] fc,
         input logic [7:0] vec, input logic u);
      note_s n;
      logic [32:0] s;
      logic [31:0] x, y;
      logic [63:0] f;
      logic v, sub;
      logic [31:0] lg [7];
      n.tr = 6'h00;
      sub = op[4:3] != 2'h0;
      x = (op[4:3] == 2'h2) ? b : a;
      y = (op[4:3] == 2'h2) ? a : b;
      y = sub ? ~y : y;
      s = {1'b0, x} + {1'b0, y} + {32'h0, op[2] ? st_m[0] : sub};
      v = (x[31] == y[31]) && (s[31] != x[31]);
      f = {a, b} << fc;
      if (op < 7'h18 && op[1:0] != 2'h3) begin
         d_m = s[31:0];
         n.tr[5:4] = {1'b1, op[0] ? v : op[1] & (s[32] ^ sub)};
         st_m = {d_m == 0, d_m[31], v, s[32]};
      end else begin
         case (op) inside
            [7'h18:7'h1E]: begin
               lg = '{a & b, a & ~b, ~(a & b), a | b, ~(a | b), a ^ b, ~(a ^ b)};
               d_m = lg[op[2:0]];
               st_m = {d_m == 0, d_m[31], 1'b0, st_m[0]};
            end
            [7'h20:7'h29]: d_m = rel_ok(op[3:0], a, b) ? `BOOL_TRUE : `BOOL_FALSE;
            7'h2A: d_m = (a[7:0] == b[7:0] || a[15:8] == b[15:8] || a[23:16] == b[23:16]
               || a[31:24] == b[31:24]) ? `BOOL_TRUE : `BOOL_FALSE;
            [7'h30:7'h39]: if (!rel_ok(op[3:0], a, b)) begin
               n.tr[3:2] = (u && vec < 8'h40) ? 2'h1 : 2'h2;
               tv_m = vec;
            end
            7'h3A: d_m = a << b[4:0];
            7'h3B: d_m = a >> b[4:0];
            7'h3C: d_m = $signed(a) >>> b[4:0];
            7'h3D: d_m = f[63:32];
            7'h40: n.tr[1] = 1'b1;
            7'h44: n.tr[0] = 1'b1;
            [7'h41:7'h43]: begin
               x = !q_m[0] ? 32'h0 : ((op == 7'h43) ? ~b + 32'h1 : b);
               s = {op != 7'h42 && a[31], a} + {op != 7'h42 && x[31], x};
               d_m = s[32:1];
               q_m = {s[0], q_m[31:1]};
            end
            7'h46, 7'h47: begin
               s = {a, q_m[31]};
               v = s >= {1'b0, b};
               x = v ? 32'(s - {1'b0, b}) : s[31:0];
               y = {q_m[30:0], v};
               {d_m, q_m} = op[0] ? {y, x} : {x, y};
            end
            7'h45: {d_m, q_m} = {a, b};
            7'h48: d_m = q_m;
            default: ;
         endcase
         n.tr[5] = op inside {[7'h18:7'h1E], [7'h20:7'h2A], [7'h3A:7'h3D], [7'h41:7'h43],
            [7'h45:7'h48]};
         if (op inside {[7'h41:7'h43], [7'h45:7'h48]}) st_m = {d_m == 0, d_m[31], 2'h0};
      end
      {n.res, n.st, n.q, n.vec} = {d_m, st_m, q_m, tv_m};
      notes.push_back(n);
      op_valid <= 1'b1;
      {opcode, first_operand, second_operand} <= {op, a, b};
      {funnel_shift_count, trap_vector_number, user_mode} <= {fc, vec, u};
      @(posedge sys_clk);
   endtask : issue

   always @(posedge sys_clk) begin : mon
      note_s n;
      #1;
      if (op_done === 1'b1) begin
         if (notes.size() == 0) chk("queue", 1, 0);
         else begin
            n = notes.pop_front();
            chk("traps", n.tr, {result_write, range_trap, assert_trap, protect_trap,
               product_trap, quotient_trap});
            chk("result", n.res, result_register);
            chk("status", n.st, alu_status);
            chk("helper", n.q, helper_q);
            chk("vector", n.vec, trap_vector);
         end
      end
   end

   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin : main
      logic [31:0] a, b, m;
      logic [63:0] p;
      logic [6:0] op;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("reset", 0, result_register | helper_q | alu_status | trap_vector);
      @(posedge sys_clk);
      for (int i = 0; i < 600; i++) begin
         seed = xs(seed);
         a = seed;
         seed = xs(seed);
         b = (seed[1:0] == 2'h1) ? a : (seed[0] ? a ^ (seed & 32'hFF00FF00) : seed);
         op = (i < 73) ? i[6:0] : seed[6:0] % 7'h49;
         issue(op, a, b, seed[12:8], seed[23:16], seed[24]);
      end
      $display("random and exhaustive ops done");
      // unsigned multiply, signed multiply, then divide with high word below divisor
      for (int j = 0; j < 3; j++) begin
         seed = xs(seed);
         m = seed;
         b = (j == 2) ? (a | 32'h1) : a;
         {op_valid, q_load, q_load_data} <= {2'b01, m};
         @(posedge sys_clk);
         q_load <= 1'b0;
         {d_m, q_m} = {32'h0, m};
         if (j == 2) issue(7'h45, a >> 1, m, 5'h0, 8'h0, 1'b0);
         for (int k = 0; k < 32; k++) begin
            op = (j == 0) ? 7'h42 : ((j == 1) ? 7'h41 : 7'h46);
            if (k == 31 && j > 0) op = op + ((j == 1) ? 7'h2 : 7'h1);
            issue(op, d_m, b, 5'h0, 8'h0, 1'b0);
         end
         op_valid <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1;
         p = {a >> 1, m};
         if (j == 0) p = 64'(m) * 64'(b);
         else if (j == 1) p = 64'($signed(m)) * 64'($signed(b));
         else p = {32'(p / b), 32'(p % b)};
         chk("sequence high", p[63:32], result_register);
         chk("sequence low", p[31:0], helper_q);
         @(posedge sys_clk);
      end
      chk("pending", 0, notes.size());
      $display("step sequences done");
      results();
   end

   initial begin : watchdog
      #40000;
      error_cnt++;
      results();
   end
endmodule : integer_alu_compare_shift_test
